/* hw/noload_detection.sv */
// No-load (anti-creep) detection for three phases of a metering DSP.
// Assumes power words arrive with a one-cycle update strobe on ref_clk
// and that the register port is driven by the serial interface logic.
//
// Notes on behaviour
// - Phase in P/Q no-load when both |P| and |Q| are at or below levels.
// - P/Q no-load phase stops active and reactive accumulation and pulses.
// - A negative active or reactive level disables P/Q no-load detection.
// - Levels are 24-bit signed, read zero-padded, sign extended to 28 bits.
// - Levels are clamped to the full-scale instantaneous power constant.
// - Status bit 0 set when P/Q no-load changes in any phase.
// - State bits 2..0 give phase C, B, A P/Q no-load, with bit 0.
// - Mask bit 0 enables interrupt low on P/Q no-load entry or exit.
// - Host reads state after status, writes 1 to clear; line releases.
// - Phase in apparent no-load when |S| at or below level; stops S.
// - A negative apparent level disables apparent no-load detection.
// - Status bit 2 set when apparent no-load changes in any phase.
// - State bits 8, 7, 6 give phase C, B, A apparent no-load.
// - Mask bit 2 enables interrupt low on apparent no-load entry or exit.
// - Status flags set whatever the mask; mask gates only the line.
// - Interrupt line stays low while any enabled flag stays set.
`timescale 1ns/1ns
`default_nettype none
module noload_detection (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic powerValid,
  input wire logic [noload_pkg::PHASES-1:0][noload_pkg::DSP_W-1:0] activePower,
  input wire logic [noload_pkg::PHASES-1:0][noload_pkg::DSP_W-1:0]
    reactivePower,
  input wire logic [noload_pkg::PHASES-1:0][noload_pkg::DSP_W-1:0]
    apparentPower,
  input wire logic [noload_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic [noload_pkg::REG_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [noload_pkg::REG_DATA_W-1:0] regRdData,
  output logic regRdValid,
  output logic gatedValid,
  output logic [noload_pkg::PHASES-1:0][noload_pkg::DSP_W-1:0] gatedActive,
  output logic [noload_pkg::PHASES-1:0][noload_pkg::DSP_W-1:0] gatedReactive,
  output logic [noload_pkg::PHASES-1:0][noload_pkg::DSP_W-1:0] gatedApparent,
  output logic [noload_pkg::PHASES-1:0] pqAccumEnable,
  output logic [noload_pkg::PHASES-1:0] apparentAccumEnable,
  output logic secondary_interrupt_n
);
  import noload_pkg::*;

  localparam int PAD_W = REG_DATA_W - DSP_W;
  localparam int EXT_W = DSP_W - LEVEL_W;

  noload_flag_if flagBus ();

  logic [LEVEL_W-1:0] activeLevel;
  logic [LEVEL_W-1:0] reactiveLevel;
  logic [LEVEL_W-1:0] apparentLevel;
  logic [PHASES-1:0] pqState;
  logic [PHASES-1:0] apparentState;
  logic [PHASES-1:0][DSP_W-1:0] gatedActiveR;
  logic [PHASES-1:0][DSP_W-1:0] gatedReactiveR;
  logic [PHASES-1:0][DSP_W-1:0] gatedApparentR;
  logic gatedValidR;
  logic [REG_DATA_W-1:0] rdData;
  logic rdValid;

  logic [LEVEL_W-1:0] next_activeLevel;
  logic [LEVEL_W-1:0] next_reactiveLevel;
  logic [LEVEL_W-1:0] next_apparentLevel;
  logic [PHASES-1:0] next_pqState;
  logic [PHASES-1:0] next_apparentState;
  logic [PHASES-1:0][DSP_W-1:0] next_gatedActive;
  logic [PHASES-1:0][DSP_W-1:0] next_gatedReactive;
  logic [PHASES-1:0][DSP_W-1:0] next_gatedApparent;
  logic next_gatedValid;
  logic [REG_DATA_W-1:0] next_rdData;
  logic next_rdValid;

  logic [DSP_W-1:0] activeLevelExt;
  logic [DSP_W-1:0] reactiveLevelExt;
  logic [DSP_W-1:0] apparentLevelExt;
  logic pqEnable;
  logic apparentEnable;
  logic [PHASES-1:0] activeBelow;
  logic [PHASES-1:0] reactiveBelow;
  logic [PHASES-1:0] apparentBelow;
  logic [REG_DATA_W-1:0] phaseStateWord;
  logic [PHASES-1:0] pqBelow;
  logic [PHASES-1:0][DSP_W-1:0] activeKept;
  logic [PHASES-1:0][DSP_W-1:0] reactiveKept;
  logic [PHASES-1:0][DSP_W-1:0] apparentKept;
  logic wrActive;
  logic wrReactive;
  logic wrApparent;
  logic wrStatus;
  logic wrMask;

  // 28-bit internal view of the 24-bit levels
  assign activeLevelExt = {{EXT_W{activeLevel[LEVEL_W-1]}}, activeLevel};
  assign reactiveLevelExt = {{EXT_W{reactiveLevel[LEVEL_W-1]}},
    reactiveLevel};
  assign apparentLevelExt = {{EXT_W{apparentLevel[LEVEL_W-1]}},
    apparentLevel};

  // a negative level would clamp to full scale and match nearly any power, so gate it explicitly
  assign pqEnable = !activeLevel[LEVEL_W-1] && !reactiveLevel[LEVEL_W-1];
  assign apparentEnable = !apparentLevel[LEVEL_W-1];

  genvar ph;
  generate
    for (ph = 0; ph < PHASES; ph++) begin : g_phase
      noload_phase_cmp activeCmp (
        .power(activePower[ph]),
        .level(activeLevelExt),
        .enable(pqEnable),
        .below(activeBelow[ph])
      );
      noload_phase_cmp reactiveCmp (
        .power(reactivePower[ph]),
        .level(reactiveLevelExt),
        .enable(pqEnable),
        .below(reactiveBelow[ph])
      );
      noload_phase_cmp apparentCmp (
        .power(apparentPower[ph]),
        .level(apparentLevelExt),
        .enable(apparentEnable),
        .below(apparentBelow[ph])
      );
      // verdict and the words passed on, taken only at an update
      assign pqBelow[ph] = activeBelow[ph] && reactiveBelow[ph];
      assign activeKept[ph] = pqBelow[ph] ? '0 : activePower[ph];
      assign reactiveKept[ph] = pqBelow[ph] ? '0 : reactivePower[ph];
      assign apparentKept[ph] = apparentBelow[ph] ? '0 :
        apparentPower[ph];
    end
  endgenerate

  always_comb begin
    phaseStateWord = WORD_RESET;
    phaseStateWord[PQ_PHASE_NOLOAD_STATE_LSB +: PHASES] = pqState;
    phaseStateWord[APPARENT_PHASE_NOLOAD_STATE_LSB +: PHASES] =
      apparentState;
  end

  // detection and energy gating
  always_comb begin
    next_pqState = pqState;
    next_apparentState = apparentState;
    next_gatedActive = gatedActiveR;
    next_gatedReactive = gatedReactiveR;
    next_gatedApparent = gatedApparentR;
    next_gatedValid = powerValid;
    if (powerValid) begin
      next_pqState = pqBelow;
      next_apparentState = apparentBelow;
      // zero power means nothing accumulates and no pulse builds up
      next_gatedActive = activeKept;
      next_gatedReactive = reactiveKept;
      next_gatedApparent = apparentKept;
    end
    // state bits and status flags move on the same edge
    flagBus.eventSet[EVT_PQ] = powerValid && (next_pqState != pqState);
    flagBus.eventSet[EVT_APPARENT] = powerValid &&
      (next_apparentState != apparentState);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pqState <= '0;
      apparentState <= '0;
      gatedActiveR <= '0;
      gatedReactiveR <= '0;
      gatedApparentR <= '0;
      gatedValidR <= 1'b0;
    end else begin
      pqState <= next_pqState;
      apparentState <= next_apparentState;
      gatedActiveR <= next_gatedActive;
      gatedReactiveR <= next_gatedReactive;
      gatedApparentR <= next_gatedApparent;
      gatedValidR <= next_gatedValid;
    end
  end

  // write decode: one strobe per writable register, unmapped offsets match none
  always_comb begin
    wrActive = 1'b0;
    wrReactive = 1'b0;
    wrApparent = 1'b0;
    wrStatus = 1'b0;
    wrMask = 1'b0;
    if (regWrite) begin
      case (regAddr)
        ACTIVE_NOLOAD_LEVEL_OFS: begin
          wrActive = 1'b1;
        end
        REACTIVE_NOLOAD_LEVEL_OFS: begin
          wrReactive = 1'b1;
        end
        APPARENT_NOLOAD_LEVEL_OFS: begin
          wrApparent = 1'b1;
        end
        SECONDARY_EVENT_STATUS_OFS: begin
          wrStatus = 1'b1;
        end
        SECONDARY_EVENT_MASK_OFS: begin
          wrMask = 1'b1;
        end
        // the phase state word is read-only, so writes to it drop here
        default: begin
        end
      endcase
    end
  end

  // levels, plus the write strobes handed to the flag unit
  always_comb begin
    next_activeLevel = activeLevel;
    next_reactiveLevel = reactiveLevel;
    next_apparentLevel = apparentLevel;
    if (wrActive) begin
      next_activeLevel = regWrData[LEVEL_W-1:0];
    end
    if (wrReactive) begin
      next_reactiveLevel = regWrData[LEVEL_W-1:0];
    end
    if (wrApparent) begin
      next_apparentLevel = regWrData[LEVEL_W-1:0];
    end
    flagBus.statusWrite = wrStatus;
    flagBus.maskWrite = wrMask;
    flagBus.writeData = regWrData;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      activeLevel <= LEVEL_RESET;
      reactiveLevel <= LEVEL_RESET;
      apparentLevel <= LEVEL_RESET;
    end else begin
      activeLevel <= next_activeLevel;
      reactiveLevel <= next_reactiveLevel;
      apparentLevel <= next_apparentLevel;
    end
  end

  // read answer: registered, so data stands one cycle after the strobe
  always_comb begin
    next_rdValid = regRead;
    next_rdData = rdData;
    if (regRead) begin
      case (regAddr)
        ACTIVE_NOLOAD_LEVEL_OFS: begin
          next_rdData = {{PAD_W{1'b0}}, activeLevelExt};
        end
        REACTIVE_NOLOAD_LEVEL_OFS: begin
          next_rdData = {{PAD_W{1'b0}}, reactiveLevelExt};
        end
        APPARENT_NOLOAD_LEVEL_OFS: begin
          next_rdData = {{PAD_W{1'b0}}, apparentLevelExt};
        end
        SECONDARY_EVENT_STATUS_OFS: begin
          next_rdData = flagBus.status;
        end
        PHASE_NOLOAD_STATE_OFS: begin
          next_rdData = phaseStateWord;
        end
        SECONDARY_EVENT_MASK_OFS: begin
          next_rdData = flagBus.mask;
        end
        default: begin
          next_rdData = WORD_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdData <= WORD_RESET;
      rdValid <= 1'b0;
    end else begin
      rdData <= next_rdData;
      rdValid <= next_rdValid;
    end
  end

  noload_event_flags flagUnit (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flagBus(flagBus.flags)
  );

  assign regRdData = rdData;
  assign regRdValid = rdValid;
  assign gatedValid = gatedValidR;
  assign gatedActive = gatedActiveR;
  assign gatedReactive = gatedReactiveR;
  assign gatedApparent = gatedApparentR;
  assign pqAccumEnable = ~pqState;
  assign apparentAccumEnable = ~apparentState;
  assign secondary_interrupt_n = flagBus.irqN;
endmodule
`default_nettype wire

/* hw/noload_pkg.sv */
// Constants shared by the no-load detection block: register offsets,
// field positions, reset values and widths.
// Assumes a single DSP clock domain and a word-wide register port.
package noload_pkg;

  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 32;
  localparam int DSP_W = 28;
  localparam int LEVEL_W = 24;
  localparam int PHASES = 3;

  // register offsets
  localparam logic [7:0] ACTIVE_NOLOAD_LEVEL_OFS = 8'h00;
  localparam logic [7:0] REACTIVE_NOLOAD_LEVEL_OFS = 8'h04;
  localparam logic [7:0] APPARENT_NOLOAD_LEVEL_OFS = 8'h08;
  localparam logic [7:0] SECONDARY_EVENT_STATUS_OFS = 8'h0c;
  localparam logic [7:0] PHASE_NOLOAD_STATE_OFS = 8'h10;
  localparam logic [7:0] SECONDARY_EVENT_MASK_OFS = 8'h14;

  // secondary event status and mask bit positions
  localparam int PQ_NOLOAD_FLAG_BIT = 0;
  localparam int APPARENT_NOLOAD_FLAG_BIT = 2;

  // phase_noload_state field positions (phase A in the low bit)
  localparam int PQ_PHASE_NOLOAD_STATE_LSB = 0;
  localparam int APPARENT_PHASE_NOLOAD_STATE_LSB = 6;

  // instantaneous power at full-scale converter inputs
  localparam logic [DSP_W-1:0] FULL_SCALE_POWER = 28'h1ff6a6b;

  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 24'h000000;
  localparam logic [REG_DATA_W-1:0] WORD_RESET = 32'h00000000;

  // event index on the flag carrier
  localparam int EVT_PQ = 0;
  localparam int EVT_APPARENT = 1;

endpackage

/* hw/noload_flag_if.sv */
// Carrier between the no-load core and its event flag unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface noload_flag_if;
  import noload_pkg::*;

  logic [1:0] eventSet;
  logic statusWrite;
  logic maskWrite;
  logic [REG_DATA_W-1:0] writeData;
  logic [REG_DATA_W-1:0] status;
  logic [REG_DATA_W-1:0] mask;
  logic irqN;

  modport core (
    output eventSet,
    output statusWrite,
    output maskWrite,
    output writeData,
    input status,
    input mask,
    input irqN
  );

  modport flags (
    input eventSet,
    input statusWrite,
    input maskWrite,
    input writeData,
    output status,
    output mask,
    output irqN
  );
endinterface
`default_nettype wire

/* hw/noload_phase_cmp.sv */
// One phase, one power: magnitude compared against a no-load level.
// Assumes the level is already sign extended to the DSP width.
`timescale 1ns/1ns
`default_nettype none
module noload_phase_cmp (
  input wire logic [noload_pkg::DSP_W-1:0] power,
  input wire logic [noload_pkg::DSP_W-1:0] level,
  input wire logic enable,
  output logic below
);
  import noload_pkg::*;

  logic [DSP_W:0] magnitude;
  logic [DSP_W:0] limit;

  always_comb begin
    // one extra bit so the most negative power has a true magnitude
    if (power[DSP_W-1]) begin
      magnitude = {1'b0, ~power} + {{DSP_W{1'b0}}, 1'b1};
    end else begin
      magnitude = {1'b0, power};
    end
    // a level past full scale means every real power counts as no-load
    if (level > FULL_SCALE_POWER) begin
      limit = {1'b0, FULL_SCALE_POWER};
    end else begin
      limit = {1'b0, level};
    end
    below = enable && (magnitude <= limit);
  end
endmodule
`default_nettype wire

/* hw/noload_event_flags.sv */
// Secondary event status and mask with the active-low interrupt line.
// Assumes event pulses are one cycle wide and on the same clock.
`timescale 1ns/1ns
`default_nettype none
module noload_event_flags (
  input wire logic ref_clk,
  input wire logic rst_n,
  noload_flag_if.flags flagBus
);
  import noload_pkg::*;

  logic [REG_DATA_W-1:0] status;
  logic [REG_DATA_W-1:0] mask;
  logic irqN;
  logic [REG_DATA_W-1:0] next_status;
  logic [REG_DATA_W-1:0] next_mask;
  logic next_irqN;

  always_comb begin
    next_status = status;
    next_mask = mask;
    if (flagBus.statusWrite) begin
      next_status = status & ~flagBus.writeData;
    end
    // set after clear so a same-cycle event survives the write
    if (flagBus.eventSet[EVT_PQ]) begin
      next_status[PQ_NOLOAD_FLAG_BIT] = 1'b1;
    end
    if (flagBus.eventSet[EVT_APPARENT]) begin
      next_status[APPARENT_NOLOAD_FLAG_BIT] = 1'b1;
    end
    if (flagBus.maskWrite) begin
      next_mask = flagBus.writeData;
    end
    // only the two implemented flags can ever be set
    next_irqN = ~|(next_status & next_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status <= WORD_RESET;
      mask <= WORD_RESET;
      irqN <= 1'b1;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irqN <= next_irqN;
    end
  end

  assign flagBus.status = status;
  assign flagBus.mask = mask;
  assign flagBus.irqN = irqN;
endmodule
`default_nettype wire

/* tb/noload_detection_checker.sv */
// Checker for the no-load block: read, update and interrupt timing.
// Assumes one clock domain; bound to every noload_detection instance.
`timescale 1ns/1ns
`default_nettype none
module noload_detection_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic powerValid,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic regRdValid,
  input wire logic gatedValid,
  input wire logic [2:0] pqAccumEnable,
  input wire logic [2:0] apparentAccumEnable,
  input wire logic secondary_interrupt_n
);
  // shadow of the mask, so line checks know which flags may pull it low
  logic [31:0] maskCopy;
  logic [31:0] next_maskCopy;
  always_comb begin
    next_maskCopy = maskCopy;
    if (regWrite && regAddr == 8'h14) begin
      next_maskCopy = regWrData;
    end
  end
  always_ff @(posedge ref_clk) begin
    maskCopy <= rst_n ? next_maskCopy : 32'h0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // no update at the same edge, else a new flag wins over the clear
  sequence clearBoth;
    regWrite && regAddr == 8'h0c && regWrData == 32'h5 && !powerValid;
  endsequence
  sequence lineLow;
    !secondary_interrupt_n && !regWrite;
  endsequence
  a_read_answer: assert property (regRead |=> regRdValid)
    else $error("read not answered");
  a_update_echo: assert property (powerValid |=> gatedValid)
    else $error("update not passed on");
  a_pq_hold: assert property (!powerValid |=> $stable(pqAccumEnable))
    else $error("pq enable moved without update");
  a_va_hold: assert property (!powerValid |=> $stable(apparentAccumEnable))
    else $error("apparent enable moved without update");
  a_pq_irq: assert property ($changed(pqAccumEnable) && maskCopy[0]
    |-> !secondary_interrupt_n) else $error("pq change left line high");
  a_va_irq: assert property ($changed(apparentAccumEnable) && maskCopy[2]
    |-> !secondary_interrupt_n) else $error("apparent change left line high");
  a_irq_masked: assert property (!maskCopy[0] && !maskCopy[2]
    |-> secondary_interrupt_n) else $error("line low while masked");
  a_irq_stays: assert property (lineLow |=> !secondary_interrupt_n)
    else $error("line released without clear");
  a_irq_release: assert property (clearBoth |=> secondary_interrupt_n)
    else $error("line not released");
endmodule
bind noload_detection noload_detection_checker chk_u (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .powerValid(powerValid),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regWrite(regWrite),
  .regRead(regRead),
  .regRdValid(regRdValid),
  .gatedValid(gatedValid),
  .pqAccumEnable(pqAccumEnable),
  .apparentAccumEnable(apparentAccumEnable),
  .secondary_interrupt_n(secondary_interrupt_n)
);
`default_nettype wire

/* tb/noload_host.sv */
// Host model: word accesses and interrupt service on the register port.
// Assumes requests start on a falling edge and are taken at the next rise.
`timescale 1ns/1ns
`default_nettype none
module noload_host (
  input wire logic ref_clk,
  input wire logic [31:0] regRdData,
  input wire logic regRdValid,
  output logic [7:0] regAddr,
  output logic [31:0] regWrData,
  output logic regWrite,
  output logic regRead
);
  initial begin
    regAddr = 8'h3c;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // released lines flip, so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge ref_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge ref_clk);
    regRead = 1'b0;
    regAddr = ~a;
    d = (regRdValid === 1'b1) ? regRdData : 'x;
  endtask
  task automatic service(output logic [31:0] st, output logic [31:0] ph);
    rd(8'h0c, st);
    rd(8'h10, ph);
    wr(8'h0c, st);
  endtask
endmodule
`default_nettype wire

/* tb/noload_detection_tb.sv */
// Bench for the no-load block: host register traffic and power updates.
// Assumes the host model owns the register port.
`timescale 1ns/1ns
`default_nettype none
module noload_detection_tb;
  import noload_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic powerValid = 1'b0;
  logic [PHASES-1:0][DSP_W-1:0] pAct = '0;
  logic [PHASES-1:0][DSP_W-1:0] pReact = '0;
  logic [PHASES-1:0][DSP_W-1:0] pApp = '0;
  logic [PHASES-1:0][DSP_W-1:0] gAct;
  logic [PHASES-1:0][DSP_W-1:0] gReact;
  logic [PHASES-1:0][DSP_W-1:0] gApp;
  logic [7:0] regAddr;
  logic [31:0] regWrData;
  logic [31:0] regRdData;
  logic regWrite;
  logic regRead;
  logic regRdValid;
  logic [2:0] pqEn;
  logic [2:0] vaEn;
  logic irqN;
  logic [31:0] st;
  logic [31:0] ph;
  int failures = 0;
  int nChecks = 0;
  int cycles = 0;
  always #50 ref_clk = ~ref_clk;
  noload_detection dut_u (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .powerValid(powerValid),
    .activePower(pAct),
    .reactivePower(pReact),
    .apparentPower(pApp),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdData(regRdData),
    .regRdValid(regRdValid),
    .gatedValid(),
    .gatedActive(gAct),
    .gatedReactive(gReact),
    .gatedApparent(gApp),
    .pqAccumEnable(pqEn),
    .apparentAccumEnable(vaEn),
    .secondary_interrupt_n(irqN)
  );
  noload_host host_u (
    .ref_clk(ref_clk),
    .regRdData(regRdData),
    .regRdValid(regRdValid),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRead(regRead)
  );
  task automatic print_verdict();
    if (failures == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // phase k gets the given powers, the others a load well above any level
  task automatic pw(input int k, input logic [27:0] p, input logic [27:0] q,
      input logic [27:0] s);
    @(negedge ref_clk);
    pAct = {3{28'h0100000}};
    pReact = {3{28'h0100000}};
    pApp = {3{28'h0100000}};
    pAct[k] = p;
    pReact[k] = q;
    pApp[k] = s;
    powerValid = 1'b1;
    @(negedge ref_clk);
    powerValid = 1'b0;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    host_u.rd(8'h10, ph);
    chk(ph, 32'h0);
    host_u.wr(8'h3c, 32'h1);
    host_u.rd(8'h3c, st);
    chk(st, 32'h0);
    host_u.wr(8'h00, 32'hff000100);
    host_u.wr(8'h04, 32'h00000100);
    host_u.wr(8'h08, 32'h00000200);
    host_u.wr(8'h14, 32'h5);
    host_u.rd(8'h00, st);
    chk(st, 32'h00000100);
    for (int k = 0; k < 3; k++) begin
      pw(k, 28'hfffff00, 28'h0000080, 28'h0000300);
      chk({irqN, pqEn, vaEn}, {1'b0, ~(3'b001 << k), 3'b111});
      chk(gAct[k], 32'h0);
      chk(gReact[k], 32'h0);
      chk(gApp[k], 32'h300);
      chk(gAct[(k + 1) % 3], 32'h0100000);
      host_u.service(st, ph);
      chk(st, 32'h1);
      chk(ph, 32'h1 << k);
      chk({31'h0, irqN}, 32'h1);
    end
    pw(2, 28'hfffff00, 28'h0000080, 28'h0000300);
    host_u.rd(8'h0c, st);
    chk(st, 32'h0);
    pw(0, 28'h0, 28'h0000101, 28'h0000200);
    chk({29'h0, vaEn}, 32'h6);
    chk(gApp[0], 32'h0);
    chk(gReact[0], 32'h101);
    host_u.service(st, ph);
    chk(st, 32'h5);
    chk(ph, 32'h40);
    host_u.wr(8'h14, 32'h0);
    pw(1, 28'h0, 28'h0, 28'h0100000);
    chk({31'h0, irqN}, 32'h1);
    host_u.service(st, ph);
    chk(st, 32'h5);
    chk(ph, 32'h2);
    host_u.wr(8'h00, 32'h00800000);
    host_u.wr(8'h04, 32'h00ffffff);
    host_u.wr(8'h08, 32'h00ffff00);
    host_u.rd(8'h08, st);
    chk(st, 32'h0fffff00);
    pw(1, 28'h0, 28'h0, 28'h0);
    host_u.rd(8'h10, ph);
    chk(ph, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
